// File: hw/ccr_control_regs.sv
// Processor control register bank with APB access and core-side controls
//
// How it works
// [R1] Fourth register reserved bits read zero
// [R2] Restrict bit set: timestamp read kernel-only
// [R3] Restrict bit clear: timestamp read everywhere
// [R4] Third register holds 4 KB page base
// [R5] Page fault loads faulting linear address
// [R6] Paging needs paging bit and protect bit
// [R7] Paging change lands after unconditional branch
// [R8] Fill disable stops fills, hits still served
// [R9] Writes update lines, snoops still invalidate
// [R10] Software invalidates cache for full disable
// [R11] Write-back: bus writes only listed cases
// [R12] Write-through: every write reaches bus
// [R13] Lock bit freezes write policy bit
// [R14] Align mask gates alignment faults
// [R15] Protected mode: kernel-only control register access
// [R16] Protect bit selects protected mode
// [R17] Reserved fields read back stored, no effect
//
// Design decisions made here: the APB slave port and the register offsets.
module ccr_control_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Core state
  input wire logic [1:0] current_privilege_level,
  input wire logic align_check_flag,
  input wire logic branch_retire,
  input wire logic page_fault,
  input wire logic [31:0] fault_linear_addr,
  input wire logic ts_read_req,
  // Cache events
  input wire logic rd_hit,
  input wire logic rd_miss,
  input wire logic wr_hit,
  input wire logic wr_miss,
  input wire logic wr_locked,
  input wire logic evict_modified,
  input wire logic flush_evict,
  input wire logic snoop_hit,
  // Controls to the core
  output logic protect_mode,
  output logic paging_active,
  output logic [19:0] page_dir_base,
  output logic align_fault_enable,
  output logic ts_read_grant,
  output logic ts_read_fault,
  // Cache decisions
  output logic cache_fill_grant,
  output logic read_hit_serve,
  output logic line_update,
  output logic snoop_invalidate,
  output logic ext_write_issue
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] ctrl_zero;
    logic [31:0] ctrl_one;
    logic [31:0] ctrl_two;
    logic [19:0] page_base;
    logic ts_restrict;
    logic [7:0] config_two;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic protect;
    logic paging;
    logic align_en;
    logic ts_grant;
    logic ts_fault;
  } ccr_state_s;

  ccr_state_s s_q;
  ccr_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_ctrl_reg(input logic [7:0] addr);
    is_ctrl_reg = (addr == ccr_pkg::OFS_CTRL_ZERO) || (addr == ccr_pkg::OFS_CTRL_ONE) ||
                  (addr == ccr_pkg::OFS_CTRL_TWO) || (addr == ccr_pkg::OFS_CTRL_THREE) ||
                  (addr == ccr_pkg::OFS_CTRL_FOUR);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_ctrl_reg(addr) || (addr == ccr_pkg::OFS_CONFIG_TWO) ||
                (addr == ccr_pkg::OFS_IRQ_STATUS) || (addr == ccr_pkg::OFS_IRQ_MASK);
  endfunction

  function automatic logic is_kernel(input logic [1:0] level);
    is_kernel = (level == ccr_pkg::PRIV_KERNEL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic setup;
    logic access;
    logic denied;
    logic [31:0] rd;
    logic [31:0] wr_zero;
    logic [3:0] events;
    logic protect_now;
    setup = psel & ~penable;
    access = psel & penable & s_q.ready;
    denied = 1'b0;
    rd = 32'h0000_0000;
    wr_zero = s_q.ctrl_zero;
    events = 4'h0;
    protect_now = s_q.ctrl_zero[ccr_pkg::BIT_PROTECT_ENABLE]; // see [R16]
    s_d = s_q;

    // Read mux; reserved parts of the zero and one registers read as stored
    unique case (paddr)
      ccr_pkg::OFS_CTRL_ZERO: rd = s_q.ctrl_zero; // see [R17]
      ccr_pkg::OFS_CTRL_ONE: rd = s_q.ctrl_one; // see [R17]
      ccr_pkg::OFS_CTRL_TWO: rd = s_q.ctrl_two;
      ccr_pkg::OFS_CTRL_THREE: rd = {s_q.page_base, 12'h000}; // see [R4]
      ccr_pkg::OFS_CTRL_FOUR: rd = {29'h0000_0000, s_q.ts_restrict, 2'h0}; // see [R1]
      ccr_pkg::OFS_CONFIG_TWO: rd = {24'h00_0000, s_q.config_two};
      ccr_pkg::OFS_IRQ_STATUS: rd = {28'h000_0000, s_q.status};
      ccr_pkg::OFS_IRQ_MASK: rd = {28'h000_0000, s_q.mask};
      default: rd = 32'h0000_0000;
    endcase

    // Answer is prepared in the setup cycle so the access phase has no waits
    s_d.ready = setup;
    if (setup) begin
      denied = is_ctrl_reg(paddr) && protect_now &&
               !is_kernel(current_privilege_level); // see [R15]
      s_d.err = denied || !is_mapped(paddr);
      s_d.rdata = s_d.err ? 32'h0000_0000 : rd;
    end
    events[ccr_pkg::EVT_ACCESS_DENIED] = denied;

    // Register writes at the completing edge only
    if (access && pwrite && !s_q.err) begin
      unique case (paddr)
        ccr_pkg::OFS_CTRL_ZERO: begin
          wr_zero = pwdata;
          // Lock holds the policy bit and flags the refused change
          if (s_q.config_two[ccr_pkg::BIT_WRITE_POLICY_LOCK]) begin
            wr_zero[ccr_pkg::BIT_NOT_WRITE_THROUGH] =
              s_q.ctrl_zero[ccr_pkg::BIT_NOT_WRITE_THROUGH]; // see [R13]
            events[ccr_pkg::EVT_POLICY_LOCKED] =
              pwdata[ccr_pkg::BIT_NOT_WRITE_THROUGH] !=
              s_q.ctrl_zero[ccr_pkg::BIT_NOT_WRITE_THROUGH]; // see [R13]
          end
          s_d.ctrl_zero = wr_zero;
        end
        ccr_pkg::OFS_CTRL_ONE: s_d.ctrl_one = pwdata; // see [R17]
        ccr_pkg::OFS_CTRL_TWO: s_d.ctrl_two = pwdata;
        ccr_pkg::OFS_CTRL_THREE: begin
          // Low twelve bits are not stored: the base is page aligned
          s_d.page_base = pwdata[31:ccr_pkg::PAGE_BASE_LSB]; // see [R4]
        end
        ccr_pkg::OFS_CTRL_FOUR: begin
          s_d.ts_restrict = pwdata[ccr_pkg::BIT_TIME_STAMP_RESTRICT]; // see [R1]
        end
        ccr_pkg::OFS_CONFIG_TWO: s_d.config_two = pwdata[7:0];
        ccr_pkg::OFS_IRQ_MASK: s_d.mask = pwdata[3:0];
        default: begin
        end
      endcase
    end

    // A fault in the same cycle as a software write wins
    if (page_fault && s_q.paging) begin
      s_d.ctrl_two = fault_linear_addr; // see [R5]
      events[ccr_pkg::EVT_PAGE_FAULT] = 1'b1;
    end

    // Timestamp read permission
    if (s_q.ts_restrict) begin
      s_d.ts_grant = ts_read_req & is_kernel(current_privilege_level); // see [R2]
    end else begin
      s_d.ts_grant = ts_read_req; // see [R3]
    end
    s_d.ts_fault = ts_read_req & ~s_d.ts_grant;
    events[ccr_pkg::EVT_TIMESTAMP_FAULT] = s_d.ts_fault;

    // Mode outputs
    s_d.protect = s_d.ctrl_zero[ccr_pkg::BIT_PROTECT_ENABLE]; // see [R16]
    // Paging state only moves at a retired unconditional branch
    if (branch_retire) begin
      s_d.paging = s_q.ctrl_zero[ccr_pkg::BIT_PAGING_ENABLE] &
                   s_q.ctrl_zero[ccr_pkg::BIT_PROTECT_ENABLE]; // see [R6] see [R7]
    end
    s_d.align_en = s_q.ctrl_zero[ccr_pkg::BIT_ALIGN_MASK] & align_check_flag; // see [R14]

    // Read clears only the bits that were actually reported; new events win
    if (access && !pwrite && !s_q.err && paddr == ccr_pkg::OFS_IRQ_STATUS) begin
      s_d.status = s_q.status & ~s_q.rdata[3:0];
    end
    s_d.status = s_d.status | events;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl_zero <= ccr_pkg::RST_CTRL_ZERO;
      s_q.ctrl_one <= ccr_pkg::RST_CTRL_ONE;
      s_q.ctrl_two <= ccr_pkg::RST_CTRL_TWO;
      s_q.page_base <= ccr_pkg::RST_PAGE_BASE;
      s_q.ts_restrict <= ccr_pkg::RST_TIME_STAMP_RESTRICT; // see [R2]
      s_q.config_two <= ccr_pkg::RST_CONFIG_TWO;
      s_q.mask <= ccr_pkg::RST_IRQ_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache policy decisions

  // Full cache shutdown is left to software invalidation after setting the bit
  ccr_write_policy u_policy (
    .pclk (pclk),
    .presetn (presetn),
    .write_back (s_q.ctrl_zero[ccr_pkg::BIT_NOT_WRITE_THROUGH]), // see [R11] see [R12]
    .cache_fill_disable (s_q.ctrl_zero[ccr_pkg::BIT_FILL_DISABLE]), // see [R8] see [R10]
    .rd_hit (rd_hit),
    .rd_miss (rd_miss),
    .wr_hit (wr_hit),
    .wr_miss (wr_miss),
    .wr_locked (wr_locked),
    .evict_modified (evict_modified),
    .flush_evict (flush_evict),
    .snoop_hit (snoop_hit),
    .cache_fill_grant (cache_fill_grant),
    .read_hit_serve (read_hit_serve),
    .line_update (line_update),
    .snoop_invalidate (snoop_invalidate),
    .ext_write_issue (ext_write_issue)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign irq = s_q.irq;
  assign protect_mode = s_q.protect;
  assign paging_active = s_q.paging;
  assign page_dir_base = s_q.page_base;
  assign align_fault_enable = s_q.align_en;
  assign ts_read_grant = s_q.ts_grant;
  assign ts_read_fault = s_q.ts_fault;

endmodule

// File: hw/ccr_write_policy.sv
// Cache fill and external write decision from the cache policy bits
module ccr_write_policy (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Policy bits
  input wire logic write_back,
  input wire logic cache_fill_disable,
  // Cache events
  input wire logic rd_hit,
  input wire logic rd_miss,
  input wire logic wr_hit,
  input wire logic wr_miss,
  input wire logic wr_locked,
  input wire logic evict_modified,
  input wire logic flush_evict,
  input wire logic snoop_hit,
  // Decisions
  output logic cache_fill_grant,
  output logic read_hit_serve,
  output logic line_update,
  output logic snoop_invalidate,
  output logic ext_write_issue
);

  typedef struct packed {
    logic fill;
    logic hit_serve;
    logic update;
    logic invalidate;
    logic ext_write;
  } ccr_policy_s;

  ccr_policy_s s_q;
  ccr_policy_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.fill = rd_miss & ~cache_fill_disable; // see [R8]
    s_d.hit_serve = rd_hit; // see [R8]
    // Resident lines keep coherent even with fills stopped
    s_d.update = wr_hit; // see [R9]
    s_d.invalidate = snoop_hit; // see [R9]
    if (write_back) begin
      s_d.ext_write = wr_miss | evict_modified | wr_locked | flush_evict; // see [R11]
    end else begin
      s_d.ext_write = wr_hit | wr_miss; // see [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cache_fill_grant = s_q.fill;
  assign read_hit_serve = s_q.hit_serve;
  assign line_update = s_q.update;
  assign snoop_invalidate = s_q.invalidate;
  assign ext_write_issue = s_q.ext_write;

endmodule

// File: inc/ccr_pkg.sv
// Shared constants for the processor control register bank
package ccr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h0c;
  localparam logic [7:0] OFS_CTRL_FOUR = 8'h10;
  localparam logic [7:0] OFS_CONFIG_TWO = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned BIT_PAGING_ENABLE = 31;
  localparam int unsigned BIT_FILL_DISABLE = 30;
  localparam int unsigned BIT_NOT_WRITE_THROUGH = 29;
  localparam int unsigned BIT_ALIGN_MASK = 18;
  localparam int unsigned BIT_PROTECT_ENABLE = 0;
  localparam int unsigned BIT_TIME_STAMP_RESTRICT = 2;
  localparam int unsigned BIT_WRITE_POLICY_LOCK = 2;
  localparam int unsigned PAGE_BASE_LSB = 12;
  localparam int unsigned PAGE_BASE_WIDTH = 20;

  // Interrupt status bits
  localparam int unsigned EVT_PAGE_FAULT = 0;
  localparam int unsigned EVT_ACCESS_DENIED = 1;
  localparam int unsigned EVT_POLICY_LOCKED = 2;
  localparam int unsigned EVT_TIMESTAMP_FAULT = 3;
  localparam int unsigned EVT_COUNT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [31:0] RST_CTRL_ZERO = 32'h0000_0010;
  localparam logic [31:0] RST_CTRL_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_TWO = 32'h0000_0000;
  localparam logic [19:0] RST_PAGE_BASE = 20'h0_0000;
  localparam logic RST_TIME_STAMP_RESTRICT = 1'b1;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // Privilege level allowed to touch the control registers
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

endpackage

// File: tb/ccr_chk_sva.sv
// Port assertions for the control register bank
module ccr_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Inputs
  input wire logic psel,
  input wire logic penable,
  input wire logic [1:0] current_privilege_level,
  input wire logic ts_read_req,
  input wire logic branch_retire,
  input wire logic rd_hit,
  input wire logic rd_miss,
  input wire logic wr_hit,
  input wire logic wr_miss,
  input wire logic snoop_hit,
  // Outputs
  input wire logic pready,
  input wire logic ts_read_grant,
  input wire logic ts_read_fault,
  input wire logic paging_active,
  input wire logic cache_fill_grant,
  input wire logic read_hit_serve,
  input wire logic line_update,
  input wire logic snoop_invalidate,
  input wire logic ext_write_issue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready pulse wrong");
  ts_kernel_a: assert property (ts_read_req && current_privilege_level == 2'h0
    |=> ts_read_grant && !ts_read_fault) else $error("kernel timestamp refused");
  fill_gate_a: assert property (!rd_miss |=> !cache_fill_grant)
    else $error("fill without miss");
  hit_serve_a: assert property (rd_hit |=> read_hit_serve)
    else $error("read hit not served");
  line_update_a: assert property (wr_hit |=> line_update)
    else $error("write hit not updated");
  snoop_inval_a: assert property (snoop_hit |=> snoop_invalidate)
    else $error("snoop not invalidated");
  miss_write_a: assert property (wr_miss |=> ext_write_issue)
    else $error("write miss not on bus");
  // Paging state moves only at a retired branch
  paging_hold_a: assert property (!branch_retire |=> $stable(paging_active))
    else $error("paging changed without branch");
  ////////////////////
  cover property (ts_read_req && current_privilege_level != 2'h0 ##1 ts_read_fault);
  cover property (branch_retire ##1 paging_active);
  cover property (rd_miss ##1 cache_fill_grant);
endmodule

bind ccr_control_regs ccr_chk i_chk (
  .pclk, .presetn, .psel, .penable, .current_privilege_level, .ts_read_req, .branch_retire,
  .rd_hit, .rd_miss, .wr_hit, .wr_miss, .snoop_hit, .pready, .ts_read_grant, .ts_read_fault,
  .paging_active, .cache_fill_grant, .read_hit_serve, .line_update, .snoop_invalidate,
  .ext_write_issue);

// File: tb/tb_top.sv
// Self-checking bench for the control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, br, pf, tsr, af;
  logic pm, pa, afe, tg, tf, er;
  logic [1:0] lvl;
  logic [7:0] paddr, ev, e;
  logic [19:0] pdb;
  logic [4:0] dec;
  logic [31:0] pwdata, prdata, fla, st, rd, v;
  logic [31:0] rv [8] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0, 32'h0};
  logic [31:0] rm [5] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_f000, 32'h4};
  int errors, samples_checked;

  ccr_control_regs i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .current_privilege_level(lvl), .align_check_flag(af), .branch_retire(br),
    .page_fault(pf), .fault_linear_addr(fla), .ts_read_req(tsr), .rd_hit(ev[0]),
    .rd_miss(ev[1]), .wr_hit(ev[2]), .wr_miss(ev[3]), .wr_locked(ev[4]),
    .evict_modified(ev[5]), .flush_evict(ev[6]), .snoop_hit(ev[7]), .protect_mode(pm),
    .paging_active(pa), .page_dir_base(pdb), .align_fault_enable(afe), .ts_read_grant(tg),
    .ts_read_fault(tf), .cache_fill_grant(dec[0]), .read_hit_serve(dec[1]),
    .line_update(dec[2]), .snoop_invalidate(dec[3]), .ext_write_issue(dec[4]));

  ////////////////////
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  // Order: fill, hit serve, update, snoop, bus write
  function automatic logic [4:0] cexp(logic [7:0] x, logic cd, logic nw);
    logic b;
    b = nw ? (x[3] | x[4] | x[5] | x[6]) : (x[2] | x[3]);
    return {b, x[7], x[2], x[0], x[1] & !cd};
  endfunction

  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(string n, logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, rd, x);
  endtask

  // Ends pulses after one cycle, then lets the registered answer land
  task automatic step;
    @(posedge pclk);
    {br, pf, tsr, ev} <= '0;
    @(posedge pclk);
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    repeat (6000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, br, pf, tsr, af, lvl, paddr, ev, pwdata, fla} = '0;
    st = 32'h0000_005a;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rv[i]) rchk("reset value", 8'(i * 4), rv[i]);
    $display("test reset done");
    repeat (4) foreach (rm[i]) begin
      v = xs();
      apb(1'b1, 8'(i * 4), v);
      rchk("ctrl readback", 8'(i * 4), v & rm[i]);
      if (i == 0) chk("protect mode", 32'(pm), 32'(v[0]));
      if (i == 3) chk("page base", 32'(pdb), 32'(v[31:12]));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");
    apb(1'b1, 8'h1c, 32'h0000_000f);
    apb(1'b1, 8'h00, 32'h0000_0001);
    lvl <= 2'h3;
    apb(1'b0, 8'h10, 32'h0);
    chk("user access", 32'(er), 32'h1);
    lvl <= 2'h0;
    @(posedge pclk);
    chk("irq raised", 32'(irq), 32'h1);
    rchk("irq status", 8'h18, 32'h0000_0002);
    @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test privilege done");
    for (int r = 0; r < 2; r++) for (int l = 0; l < 4; l++) begin
      apb(1'b1, 8'h10, 32'(r * 4));
      lvl <= 2'(l);
      tsr <= 1'b1;
      step();
      chk("timestamp", 32'({tg, tf}), (r == 1 && l != 0) ? 32'h1 : 32'h2);
      lvl <= 2'h0;
    end
    $display("test timestamp done");
    apb(1'b1, 8'h00, 32'h8000_0001);
    chk("paging held", 32'(pa), 32'h0);
    br <= 1'b1;
    step();
    chk("paging on", 32'(pa), 32'h1);
    fla <= xs();
    pf <= 1'b1;
    step();
    rchk("fault address", 8'h08, fla);
    apb(1'b1, 8'h00, 32'h8000_0000);
    br <= 1'b1;
    step();
    chk("paging off", 32'(pa), 32'h0);
    $display("test paging done");
    apb(1'b1, 8'h14, 32'h0000_0004);
    apb(1'b1, 8'h00, 32'h2004_0000);
    rchk("locked policy", 8'h00, 32'h0004_0000);
    apb(1'b1, 8'h14, 32'h0);
    // Timestamp refusals, the page fault and the refused policy change are all pending
    rchk("event status", 8'h18, 32'h0000_000d);
    $display("test lock done");
    repeat (24) begin
      v = xs() & 32'h6004_0000;
      af <= st[3];
      apb(1'b1, 8'h00, v);
      e = 8'(xs());
      ev <= e;
      step();
      chk("cache", 32'(dec), 32'(cexp(e, v[30], v[29])));
      chk("align", 32'(afe), 32'(v[18] & af));
    end
    $display("test cache done");
    give_verdict();
  end
endmodule
